// ===== link_tpg_defs.vh
/*
 * Constants for the serial link test pattern generator: register byte
 * offsets, control fields, pattern codes, injection points and seeds.
 * Assumes it is included by bare name into the generator module only.
 */
`ifndef LINK_TPG_DEFS_VH
`define LINK_TPG_DEFS_VH

// Register byte offsets on the AXI4-Lite slave.
`define REG_CFG 8'h00
`define REG_TMODE 8'h04
`define REG_UP1 8'h08
`define REG_UP2 8'h0c
`define REG_UP3 8'h10
`define REG_UP4 8'h14
`define REG_STAT 8'h18

// Soft reset command and reset values.
`define SOFT_RST_CMD 8'h81
`define TMODE_RST 8'h00
`define UP_RST 16'h0000

// Test-mode control fields.
`define TM_TYPE 3:0
`define TM_POINT 5:4

// Pattern type codes.
`define PT_OFF 4'h0
`define PT_CHECK 4'h1
`define PT_TOGGLE 4'h2
`define PT_PN23 4'h4
`define PT_PN9 4'h6
`define PT_RAMP 4'h8
`define PT_UREP 4'he
`define PT_USGL 4'hf

// Injection points.
`define INJ_SAMPLE 2'h0
`define INJ_PHY 2'h1
`define INJ_SCR 2'h2

// Pattern values.
`define CHK8_A 8'h55
`define CHK8_B 8'haa
`define CHK10_A 10'h155
`define CHK10_B 10'h2aa
`define ONES10 10'h3ff
`define ONES8 8'hff

// Pseudo-random seeds, emitted least significant bit first.
`define PN9_SEED 9'h092
`define PN23_SEED 23'h003aff
`define PN9_TAP 4
`define PN23_TAP 5

// User pattern slices for each word width.
`define UP_SLICE10 15:6
`define UP_SLICE8 15:9

// AXI responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== serial_link_test_pattern_gen.v
/*
 * Serial link transmit test pattern generator with an AXI4-Lite register
 * slave. Replaces live sample, 10-bit symbol or 8-bit octet data with a
 * checkerboard, toggle, ramp, pseudo-random or user pattern.
 * Assumes one clock, word strobes synchronous to it, and a controller that
 * soft-resets before returning to normal mode.
 */
// Chosen here: register access over AXI4-Lite and the register addresses.
// Notes on behaviour
// - Two-bit field picks injection: 0 samples, 1 10-bit symbols, 2 octets.
// - Sample injection: same value in all four slots; advance once per frame.
// - Sample checkerboard 0x55/0xAA, toggle 0x00/0xFF, first value at frame zero.
// - Symbol checkerboard 0x155/0x2AA, toggle 0x000/0x3FF, first value at zero.
// - Symbol ramp wraps at 1024; user words use bits fifteen to six.
// - Octets: same alternations, ramp wraps at 256, user bits fifteen to nine.
// - User repeat cycles patterns one to four; single sends four then zeros.
// - Eight-bit PN9 starts 0x49,0x6F,0xC9; PN23 starts 0xFF,0x5C,0x00.
// - A four-bit code in the same register selects the pattern type.
`timescale 1ns/1ps
`default_nettype none
`include "link_tpg_defs.vh"

module serial_link_test_pattern_gen #(
	parameter SLOTS = 4, // Converters times samples per frame.
	parameter AW = 8 // Register address width.
) (
	input wire clk_i, // System clock, 100 MHz.
	input wire sys_rst_i, // Asynchronous reset, active high.
	input wire [AW-1:0] s_axi_awaddr, // Write address.
	input wire s_axi_awvalid, // Write address valid.
	output wire s_axi_awready, // Write address ready.
	input wire [31:0] s_axi_wdata, // Write data.
	input wire [3:0] s_axi_wstrb, // Write byte strobes.
	input wire s_axi_wvalid, // Write data valid.
	output wire s_axi_wready, // Write data ready.
	output reg [1:0] s_axi_bresp, // Write response.
	output reg s_axi_bvalid, // Write response valid.
	input wire s_axi_bready, // Write response ready.
	input wire [AW-1:0] s_axi_araddr, // Read address.
	input wire s_axi_arvalid, // Read address valid.
	output wire s_axi_arready, // Read address ready.
	output reg [31:0] s_axi_rdata, // Read data.
	output reg [1:0] s_axi_rresp, // Read response.
	output reg s_axi_rvalid, // Read data valid.
	input wire s_axi_rready, // Read data ready.
	input wire smp_valid_i, // Frame strobe with live samples.
	input wire [SLOTS*8-1:0] smp_data_i, // Live samples, slot 0 in low byte.
	output reg smp_valid_o, // Frame strobe out.
	output reg [SLOTS*8-1:0] smp_data_o, // Samples out.
	input wire phy_valid_i, // Symbol strobe with live 10-bit symbol.
	input wire [9:0] phy_data_i, // Live 10-bit symbol.
	output reg phy_valid_o, // Symbol strobe out.
	output reg [9:0] phy_data_o, // Symbol out.
	input wire scr_valid_i, // Octet strobe with live scrambler input.
	input wire [7:0] scr_data_i, // Live octet.
	output reg scr_valid_o, // Octet strobe out.
	output reg [7:0] scr_data_o, // Octet out.
	output wire test_active_o // High while a pattern is injected.
);

	// One-hot states of the user pattern sequencer.
	localparam [4:0] ST_UP1 = 5'b00001;
	localparam [4:0] ST_UP2 = 5'b00010;
	localparam [4:0] ST_UP3 = 5'b00100;
	localparam [4:0] ST_UP4 = 5'b01000;
	localparam [4:0] ST_ZERO = 5'b10000;

	reg aw_hold_q, w_hold_q, soft_rst_q, restart_q, phase_q;
	reg [AW-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg [7:0] tmode_q;
	reg [15:0] user_pattern_one_q, user_pattern_two_q, user_pattern_three_q, user_pattern_four_q;
	reg [9:0] ramp_q;
	reg [8:0] pn9_q;
	reg [22:0] pn23_q;
	reg [4:0] ust_q;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel.

	// Address and data are latched independently; the write lands once both are held.
	wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	wire wr_known = (awaddr_q == `REG_CFG) || (awaddr_q == `REG_TMODE) ||
		(awaddr_q == `REG_UP1) || (awaddr_q == `REG_UP2) ||
		(awaddr_q == `REG_UP3) || (awaddr_q == `REG_UP4);
	assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;

	// Channel holds and the write response.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= {AW{1'b0}};
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Merges the strobed bytes of the lower half word into an old value.
	function [15:0] merge16;
		input [15:0] old_v;
		input [15:0] new_v;
		input [1:0] strb;
		begin
			merge16 = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
		end
	endfunction

	// Control registers. A soft reset returns them all to defaults.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tmode_q <= `TMODE_RST;
			user_pattern_one_q <= `UP_RST;
			user_pattern_two_q <= `UP_RST;
			user_pattern_three_q <= `UP_RST;
			user_pattern_four_q <= `UP_RST;
			soft_rst_q <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			// The command bits clear themselves; the register reads back zero.
			soft_rst_q <= wr_go && (awaddr_q == `REG_CFG) && wstrb_q[0] &&
				(wdata_q[7:0] == `SOFT_RST_CMD);
			// Any write of the mode register with byte 0 strobed counts as entering a mode.
			restart_q <= soft_rst_q || (wr_go && (awaddr_q == `REG_TMODE) && wstrb_q[0]);
			if (soft_rst_q) begin
				tmode_q <= `TMODE_RST;
				user_pattern_one_q <= `UP_RST;
				user_pattern_two_q <= `UP_RST;
				user_pattern_three_q <= `UP_RST;
				user_pattern_four_q <= `UP_RST;
			end else if (wr_go) begin
				if ((awaddr_q == `REG_TMODE) && wstrb_q[0])
					tmode_q <= wdata_q[7:0];
				if (awaddr_q == `REG_UP1)
					user_pattern_one_q <= merge16(user_pattern_one_q, wdata_q[15:0], wstrb_q[1:0]);
				if (awaddr_q == `REG_UP2)
					user_pattern_two_q <= merge16(user_pattern_two_q, wdata_q[15:0], wstrb_q[1:0]);
				if (awaddr_q == `REG_UP3)
					user_pattern_three_q <= merge16(user_pattern_three_q, wdata_q[15:0], wstrb_q[1:0]);
				if (awaddr_q == `REG_UP4)
					user_pattern_four_q <= merge16(user_pattern_four_q, wdata_q[15:0], wstrb_q[1:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pattern selection and current word.

	wire [3:0] ptype = tmode_q[`TM_TYPE];
	wire [1:0] point = tmode_q[`TM_POINT];
	wire wide = (point == `INJ_PHY);
	// Codes without a generator here leave the live data untouched.
	wire type_ok = (ptype == `PT_CHECK) || (ptype == `PT_TOGGLE) || (ptype == `PT_PN23) ||
		(ptype == `PT_PN9) || (ptype == `PT_RAMP) || (ptype == `PT_UREP) ||
		(ptype == `PT_USGL);
	wire inj_smp = type_ok && (point == `INJ_SAMPLE);
	wire inj_phy = type_ok && (point == `INJ_PHY);
	wire inj_scr = type_ok && (point == `INJ_SCR);
	assign test_active_o = type_ok && (point != 2'h3);
	// The generator steps only on the strobe of the point it feeds.
	wire step = (inj_smp & smp_valid_i) | (inj_phy & phy_valid_i) | (inj_scr & scr_valid_i);

	reg [9:0] pn9_word, pn23_word;
	reg [8:0] pn9_nx8, pn9_nx10, s9;
	reg [22:0] pn23_nx8, pn23_nx10, s23;
	integer i;

	// Serial LFSR unrolled over one word; the first bit out is the word's MSB.
	always @* begin
		s9 = pn9_q;
		s23 = pn23_q;
		pn9_word = 10'h000;
		pn23_word = 10'h000;
		pn9_nx8 = pn9_q;
		pn23_nx8 = pn23_q;
		for (i = 0; i < 10; i = i + 1) begin
			pn9_word = {pn9_word[8:0], s9[0]};
			pn23_word = {pn23_word[8:0], s23[0]};
			s9 = {s9[0] ^ s9[`PN9_TAP], s9[8:1]};
			s23 = {s23[0] ^ s23[`PN23_TAP], s23[22:1]};
			if (i == 7) begin
				pn9_nx8 = s9;
				pn23_nx8 = s23;
			end
		end
		pn9_nx10 = s9;
		pn23_nx10 = s23;
	end

	reg [15:0] user_word;
	reg [9:0] pat;

	// User word of the current sequencer state; zeros once a single run ends.
	always @* begin
		case (ust_q)
			ST_UP1: user_word = user_pattern_one_q;
			ST_UP2: user_word = user_pattern_two_q;
			ST_UP3: user_word = user_pattern_three_q;
			ST_UP4: user_word = user_pattern_four_q;
			default: user_word = `UP_RST;
		endcase
	end

	// Current pattern word; eight-bit points use the low byte. For eight-bit
	// points the PN word is the first eight bits of the serial stream.
	always @* begin
		case (ptype)
			`PT_CHECK: pat = wide ? (phase_q ? `CHK10_B : `CHK10_A) :
				{2'b00, phase_q ? `CHK8_B : `CHK8_A};
			`PT_TOGGLE: pat = wide ? (phase_q ? `ONES10 : 10'h000) :
				{2'b00, phase_q ? `ONES8 : 8'h00};
			`PT_PN9: pat = wide ? pn9_word : {2'b00, pn9_word[9:2]};
			`PT_PN23: pat = wide ? pn23_word : {2'b00, pn23_word[9:2]};
			`PT_RAMP: pat = wide ? ramp_q : {2'b00, ramp_q[7:0]};
			`PT_UREP, `PT_USGL: pat = wide ? user_word[`UP_SLICE10] :
				{3'b000, user_word[`UP_SLICE8]};
			default: pat = 10'h000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Generator state.

	// All generators restart from defined values on mode entry.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase_q <= 1'b0;
			ramp_q <= 10'h000;
			pn9_q <= `PN9_SEED;
			pn23_q <= `PN23_SEED;
			ust_q <= ST_UP1;
		end else if (restart_q) begin
			phase_q <= 1'b0;
			ramp_q <= 10'h000;
			pn9_q <= `PN9_SEED;
			pn23_q <= `PN23_SEED;
			ust_q <= ST_UP1;
		end else if (step) begin
			phase_q <= ~phase_q;
			// Narrow points wrap at 256, the symbol point at 1024.
			ramp_q <= wide ? ramp_q + 10'h001 : {2'b00, ramp_q[7:0] + 8'h01};
			pn9_q <= wide ? pn9_nx10 : pn9_nx8;
			pn23_q <= wide ? pn23_nx10 : pn23_nx8;
			case (ust_q)
				ST_UP1: ust_q <= ST_UP2;
				ST_UP2: ust_q <= ST_UP3;
				ST_UP3: ust_q <= ST_UP4;
				ST_UP4: ust_q <= (ptype == `PT_USGL) ? ST_ZERO : ST_UP1;
				ST_ZERO: ust_q <= ST_ZERO;
				default: ust_q <= ST_UP1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Datapath outputs, one register stage on every path.

	// Live data passes when the point is not selected; strobes pass unchanged.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			smp_valid_o <= 1'b0;
			smp_data_o <= {SLOTS*8{1'b0}};
			phy_valid_o <= 1'b0;
			phy_data_o <= 10'h000;
			scr_valid_o <= 1'b0;
			scr_data_o <= 8'h00;
		end else begin
			smp_valid_o <= smp_valid_i;
			phy_valid_o <= phy_valid_i;
			scr_valid_o <= scr_valid_i;
			if (smp_valid_i)
				smp_data_o <= inj_smp ? {SLOTS{pat[7:0]}} : smp_data_i;
			if (phy_valid_i)
				phy_data_o <= inj_phy ? pat : phy_data_i;
			if (scr_valid_i)
				scr_data_o <= inj_scr ? pat[7:0] : scr_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel.

	reg [31:0] rd_mux;
	reg rd_ok;

	// Read decode; the command register always reads zero.
	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`REG_CFG: rd_mux = 32'h0000_0000;
			`REG_TMODE: rd_mux = {24'h00_0000, tmode_q};
			`REG_UP1: rd_mux = {16'h0000, user_pattern_one_q};
			`REG_UP2: rd_mux = {16'h0000, user_pattern_two_q};
			`REG_UP3: rd_mux = {16'h0000, user_pattern_three_q};
			`REG_UP4: rd_mux = {16'h0000, user_pattern_four_q};
			`REG_STAT: rd_mux = {16'h0000, test_active_o, ust_q, pat};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = ~s_axi_rvalid;

	// Read data is registered and held until the master takes it.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // serial_link_test_pattern_gen
`default_nettype wire

// ===== tpg_properties.sv
/* Port checker for the pattern generator: register handshakes and strobe timing.
 Assumes one clock and an active-high asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module tpg_properties (
	input wire logic clk_i, // Clock.
	input wire logic sys_rst_i, // Reset.
	input wire logic s_axi_awvalid, // Bus.
	input wire logic s_axi_awready, // Bus.
	input wire logic s_axi_wvalid, // Bus.
	input wire logic s_axi_wready, // Bus.
	input wire logic s_axi_bvalid, // Bus.
	input wire logic s_axi_arvalid, // Bus.
	input wire logic s_axi_arready, // Bus.
	input wire logic [31:0] s_axi_rdata, // Bus.
	input wire logic s_axi_rvalid, // Bus.
	input wire logic s_axi_rready, // Bus.
	input wire logic smp_valid_i, // Frame in.
	input wire logic smp_valid_o, // Frame out.
	input wire logic phy_valid_i, // Symbol in.
	input wire logic phy_valid_o, // Symbol out.
	input wire logic [9:0] phy_data_o, // Symbol.
	input wire logic scr_valid_i, // Octet in.
	input wire logic scr_valid_o // Octet out.
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Both halves of a write in one edge. The write lands one edge later, so bvalid
	// is first seen high at the second edge after the one that takes both halves.
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_both |=> ##1 s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("ready while answering");
	a_smp_latency: assert property (smp_valid_i |=> smp_valid_o)
		else $error("frame strobe lost");
	a_phy_latency: assert property (phy_valid_o |-> $past(phy_valid_i))
		else $error("spurious symbol strobe");
	a_scr_latency: assert property (scr_valid_i |=> scr_valid_o)
		else $error("octet strobe lost");
	a_phy_hold: assert property (!phy_valid_i |=> $stable(phy_data_o))
		else $error("symbol changed without strobe");
endmodule // tpg_properties
bind serial_link_test_pattern_gen tpg_properties i_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .smp_valid_i(smp_valid_i), .smp_valid_o(smp_valid_o),
	.phy_valid_i(phy_valid_i), .phy_valid_o(phy_valid_o), .phy_data_o(phy_data_o),
	.scr_valid_i(scr_valid_i), .scr_valid_o(scr_valid_o));
`default_nettype wire

// ===== tpg_link_rx.sv
/* Far-end receiver model: latches each word the generator emits.
 Assumes the bench strobes one injection point at a time. */
`timescale 1ns/1ps
`default_nettype none
module tpg_link_rx (
	input wire logic clk_i, // Clock.
	input wire logic smp_v_i, // Frame strobe.
	input wire logic [31:0] smp_d_i, // Frame.
	input wire logic phy_v_i, // Symbol strobe.
	input wire logic [9:0] phy_d_i, // Symbol.
	input wire logic scr_v_i, // Octet strobe.
	input wire logic [7:0] scr_d_i, // Octet.
	output logic [31:0] word_o // Last word, zero extended.
);
	// Only strobed words count; idle data between strobes is ignored.
	always @(posedge clk_i) begin
		if (smp_v_i) word_o <= smp_d_i;
		else if (phy_v_i) word_o <= {22'h0, phy_d_i};
		else if (scr_v_i) word_o <= {24'h0, scr_d_i};
	end
endmodule // tpg_link_rx
`default_nettype wire

// ===== tb.sv
/* Self-checking bench for the pattern generator, one task per scenario.
 Assumes the generator, its checker and the receiver model are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [15:0] U1 = 16'h8040, U2 = 16'h4fc0, U3 = 16'hffff, U4 = 16'h1234;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, smp_vi = 1'b0, phy_vi = 1'b0, scr_vi = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, scr_di = 8'h3c;
	logic [31:0] wdata = 32'h0, smp_di = 32'h11223344;
	logic [9:0] phy_di = 10'h2c1;
	wire logic awready, wready, bvalid, arready, rvalid, smp_vo, phy_vo, scr_vo, tact;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata, smp_do, rx_word;
	wire logic [9:0] phy_do;
	wire logic [7:0] scr_do;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	serial_link_test_pattern_gen i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.smp_valid_i(smp_vi), .smp_data_i(smp_di), .smp_valid_o(smp_vo), .smp_data_o(smp_do),
		.phy_valid_i(phy_vi), .phy_data_i(phy_di), .phy_valid_o(phy_vo), .phy_data_o(phy_do),
		.scr_valid_i(scr_vi), .scr_data_i(scr_di), .scr_valid_o(scr_vo), .scr_data_o(scr_do),
		.test_active_o(tact));
	tpg_link_rx i_rx (.clk_i(clk_i), .smp_v_i(smp_vo), .smp_d_i(smp_do), .phy_v_i(phy_vo),
		.phy_d_i(phy_do), .scr_v_i(scr_vo), .scr_d_i(scr_do), .word_o(rx_word));
	always #5 clk_i = ~clk_i;
	// A hang is cut short well beyond the few hundred cycles the run needs.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks: ready and answers are sampled at mid-cycle, acted on after the edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ha, hw, done;
		done = 1'b0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(negedge clk_i);
			ha = awready;
			hw = wready;
			done = bvalid;
			r = bresp;
			@(posedge clk_i);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (done) bready <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic h, done;
		done = 1'b0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(negedge clk_i);
			h = arready;
			done = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_i);
			if (h) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
	endtask
	// Enter a mode, strobe its point five times, compare each word at the far end.
	task automatic pat(input logic [7:0] tm, input logic [9:0] e0, e1, e2, e3, e4);
		logic [9:0] e [5];
		logic [1:0] r;
		e = '{e0, e1, e2, e3, e4};
		wr(8'h04, {24'h0, tm}, r);
		repeat (2) @(posedge clk_i);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_i);
			if (tm[5:4] == 2'h0) smp_vi <= 1'b1;
			else if (tm[5:4] == 2'h1) phy_vi <= 1'b1;
			else scr_vi <= 1'b1;
			@(posedge clk_i);
			{smp_vi, phy_vi, scr_vi} <= 3'b000;
			@(posedge clk_i);
			@(negedge clk_i);
			chk(rx_word, tm[5:4] == 2'h0 ? {4{e[i][7:0]}} : {22'h0, e[i]});
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		chk({31'h0, tact}, 32'h0);
		rd(8'h04, d, r);
		chk(d, 32'h0);
		rd(8'h1c, d, r);
		chk({r, d[29:0]}, {2'b10, 30'h0});
		wr(8'h08, {16'h0, U1}, r);
		wr(8'h0c, {16'h0, U2}, r);
		wr(8'h10, {16'h0, U3}, r);
		wr(8'h14, {16'h0, U4}, r);
		wr(8'h18, 32'h5, r);
		chk({30'h0, r}, 32'h2);
		rd(8'h10, d, r);
		chk(d, {16'h0, U3});
	endtask
	task automatic t_phy;
		pat(8'h11, 10'h155, 10'h2aa, 10'h155, 10'h2aa, 10'h155);
		chk({31'h0, tact}, 32'h1);
		pat(8'h12, 10'h000, 10'h3ff, 10'h000, 10'h3ff, 10'h000);
		pat(8'h18, 10'h000, 10'h001, 10'h002, 10'h003, 10'h004);
		pat(8'h1e, U1[15:6], U2[15:6], U3[15:6], U4[15:6], U1[15:6]);
		pat(8'h16, 10'h125, 10'h2fc, 10'h26a, 10'h198, 10'h031);
		pat(8'h14, 10'h3fd, 10'h1c0, 10'h00a, 10'h1b8, 10'h028);
	endtask
	task automatic t_scr;
		pat(8'h21, 10'h55, 10'haa, 10'h55, 10'haa, 10'h55);
		pat(8'h22, 10'h00, 10'hff, 10'h00, 10'hff, 10'h00);
		pat(8'h28, 10'h00, 10'h01, 10'h02, 10'h03, 10'h04);
		pat(8'h2f, U1[15:9], U2[15:9], U3[15:9], U4[15:9], 10'h0);
		pat(8'h26, 10'h49, 10'h6f, 10'hc9, 10'ha9, 10'h98);
		pat(8'h24, 10'hff, 10'h5c, 10'h00, 10'h29, 10'hb8);
		// Point code 3 selects no injection point, so live octets pass.
		pat(8'h31, 10'h3c, 10'h3c, 10'h3c, 10'h3c, 10'h3c);
		chk({31'h0, tact}, 32'h0);
	endtask
	task automatic t_smp;
		pat(8'h01, 10'h55, 10'haa, 10'h55, 10'haa, 10'h55);
		pat(8'h02, 10'h00, 10'hff, 10'h00, 10'hff, 10'h00);
		pat(8'h0f, U1[15:9], U2[15:9], U3[15:9], U4[15:9], 10'h0);
		pat(8'h08, 10'h00, 10'h01, 10'h02, 10'h03, 10'h04);
		pat(8'h06, 10'h49, 10'h6f, 10'hc9, 10'ha9, 10'h98);
	endtask
	task automatic t_soft_reset;
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h00, 32'h81, r);
		repeat (2) @(posedge clk_i);
		rd(8'h04, d, r);
		chk(d, 32'h0);
		pat(8'h10, 10'h2c1, 10'h2c1, 10'h2c1, 10'h2c1, 10'h2c1);
		chk({31'h0, tact}, 32'h0);
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_phy();
		t_scr();
		t_smp();
		t_soft_reset();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
